// File: fifo_pkg.sv
// Package with the constants, field layouts and carriers of the dual clock FIFO write block.
package fifo_pkg;

  localparam int DATA_W = 18;
  localparam int DEPTH_WORDS = 1024;
  localparam int CASCADE_DEVICES = 1;
  localparam int OFFSET_W = 9;
  localparam logic [OFFSET_W-1:0] DEFAULT_OFFSET = 9'h100;
  localparam int READ_LATENCY_PER_DEVICE = 3;
  localparam int WRITE_RECOVERY_PER_DEVICE = 2;
  localparam int SYNC_STAGES = 2;

  // Register map, byte addresses.
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] MASK_ADDR = 8'h04;
  localparam logic [7:0] LEVEL_ADDR = 8'h08;
  localparam logic [7:0] OFFSET_ADDR = 8'h0c;

  // Event bit positions, shared by status and mask.
  localparam int EV_FULL = 0;
  localparam int EV_EMPTY = 1;
  localparam int EV_HALF = 2;
  localparam int EV_ALMOST = 3;
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] STATUS_RESET = 4'h0;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

  // Level register field positions.
  localparam int LEVEL_IR_BIT = 16;
  localparam int LEVEL_OR_BIT = 17;
  localparam int LEVEL_HF_BIT = 18;
  localparam int LEVEL_AF_BIT = 19;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin inputs that cross into the aclk domain.
  typedef struct packed {
    logic wr_clk;
    logic rd_clk_a;
    logic reset_n;
    logic define_flag_offset_n;
    logic write_enable_a;
    logic write_enable_b;
    logic read_enable_a;
    logic read_enable_b;
    logic q_drive_enable;
    logic [DATA_W-1:0] data_in;
  } pin_in_type;

  // Status flags driven to the pins.
  typedef struct packed {
    logic input_ready;
    logic output_ready;
    logic half_full_flag;
    logic almost_full_empty_flag;
  } flags_type;

endpackage

// File: pin_sync.sv
// Two stage synchroniser for a bundle of pin inputs.
`timescale 1ns/10ps
module pin_sync
  import fifo_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bundle
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  initial
  begin
    if (WIDTH < 1) $error("pin_sync needs a positive width.");
  end

  // Only the second stage reads the first, which keeps metastability contained.
  always_comb
  begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
    if (!aresetn)
    begin
      nxt_meta = '0;
      nxt_sync = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign sync_out = sync_ff;

endmodule // pin_sync

// File: fifo_write_flags.sv
// Dual clock FIFO core with offset programming, flags, cascade timing and an AXI4-Lite status port.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// [R1] Store data_in on wr_clk rise only with input_ready and both write enables high.
// [R2] input_ready changes only on wr_clk rising edges.
// [R3] Writer supplies wr_clk free running; it times every transfer into the FIFO.
// [R4] Offset load ignores the write enables; they gate array writes only.
// [R5] Offset is the unsigned value of data_in bits eight down to zero.
// [R6] Offset bits captured on falling define_flag_offset_n; writer holds them stable then.
// [R7] Define strobe low through reset release arms the flag with the captured offset.
// [R8] Define strobe high at reset release selects the default offset.
// [R9] Reset held low past the fourth rising edge of both pin clocks.
// [R10] Cascade of N: first word and output_ready appear after 3N read clocks.
// [R11] Cascade of N: after full and an unload, input_ready returns after 2N write clocks.
// [R12] Next word delivered on rd_clk_a rise only with output_ready, drive and read enables.
// [R13] First word appears on the third read clock without needing read enables.
// [R14] Reset clears pointers, drops output_ready, half_full, input_ready, raises almost flag.
// [R15] Default offset is 256 words.
// [R16] input_ready low while all locations are full, high while one is free.
// [R17] half_full above half capacity; almost flag within offset of empty or full.
module fifo_write_flags
  import fifo_pkg::*;
#(
  parameter int DEPTH = DEPTH_WORDS,
  parameter int CASCADE_N = CASCADE_DEVICES
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Device pins
  input wire pin_in_type pins,
  output logic [DATA_W-1:0] data_out,
  output logic data_out_oe,
  output flags_type flags,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(DEPTH / 2);
  localparam logic [7:0] OR_DELAY = 8'(READ_LATENCY_PER_DEVICE * CASCADE_N - 1);
  localparam logic [7:0] IR_DELAY = 8'(WRITE_RECOVERY_PER_DEVICE * CASCADE_N - 1);

  initial
  begin
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two of at least 4.");
    if (CASCADE_N < 1 || CASCADE_N > 80) $error("CASCADE_N must lie between 1 and 80.");
  end

  pin_in_type pins_s;
  pin_in_type pins_d_ff;

  pin_sync #(.WIDTH($bits(pin_in_type))) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pins),
    .sync_out(pins_s)
  );

  always_ff @(posedge aclk)
  begin
    pins_d_ff <= aresetn ? pins_s : '0;
  end

  logic wr_rise;
  logic rd_rise;
  logic def_fall;
  logic rst_rise;
  logic dev_rst;
  // Pin clocks are sampled, so they must run well below half of aclk.
  assign wr_rise = pins_s.wr_clk && !pins_d_ff.wr_clk;
  assign rd_rise = pins_s.rd_clk_a && !pins_d_ff.rd_clk_a;
  assign def_fall = !pins_s.define_flag_offset_n && pins_d_ff.define_flag_offset_n;
  assign rst_rise = pins_s.reset_n && !pins_d_ff.reset_n;
  assign dev_rst = !aresetn || !pins_s.reset_n; // [R9]

  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [CNT_W-1:0] count_ff, nxt_count, occ_ff, nxt_occ;
  logic [OFFSET_W-1:0] cap_ff, nxt_cap, offset_ff, nxt_offset;
  logic [7:0] lat_ff, nxt_lat, ir_cnt_ff, nxt_ir_cnt;
  logic full_seen_ff, nxt_full_seen;
  logic [DATA_W-1:0] dout_ff, nxt_dout;
  logic oe_ff, nxt_oe;
  flags_type flags_ff, nxt_flags;
  logic push, pop, read_go;

  assign push = wr_rise && flags_ff.input_ready && pins_s.write_enable_a && pins_s.write_enable_b; // [R1]
  assign read_go = rd_rise && flags_ff.output_ready && pins_s.q_drive_enable
    && pins_s.read_enable_a && pins_s.read_enable_b; // [R12]
  // The first word is moved after the cascade latency, read enables play no part.
  assign pop = (count_ff != '0) && (flags_ff.output_ready ? read_go : (rd_rise && lat_ff == OR_DELAY)); // [R10] [R13]

  always_comb
  begin
    nxt_wr_ptr = wr_ptr_ff + PTR_W'(push);
    nxt_rd_ptr = rd_ptr_ff + PTR_W'(pop);
    nxt_count = count_ff + CNT_W'(push) - CNT_W'(pop);
    nxt_cap = def_fall ? pins_s.data_in[OFFSET_W-1:0] : cap_ff; // [R4] [R5] [R6]
    nxt_offset = offset_ff;
    nxt_lat = lat_ff;
    nxt_ir_cnt = ir_cnt_ff;
    nxt_full_seen = full_seen_ff;
    nxt_dout = pop ? mem[rd_ptr_ff] : dout_ff;
    nxt_oe = pins_s.q_drive_enable;
    nxt_flags = flags_ff;
    if (rd_rise)
    begin
      if (pop)
        nxt_flags.output_ready = 1'b1;
      else if (read_go)
        nxt_flags.output_ready = 1'b0;
      if (flags_ff.output_ready || count_ff == '0 || pop)
        nxt_lat = '0;
      else
        nxt_lat = lat_ff + 8'h01;
    end
    nxt_occ = nxt_count + CNT_W'(nxt_flags.output_ready);
    if (wr_rise)
    begin
      if (nxt_occ == FULL_CNT) // [R16]
      begin
        nxt_flags.input_ready = 1'b0;
        nxt_full_seen = 1'b1;
        nxt_ir_cnt = '0;
      end
      else if (!full_seen_ff || ir_cnt_ff == IR_DELAY) // [R11]
      begin
        nxt_flags.input_ready = 1'b1; // [R2]
        nxt_full_seen = 1'b0;
      end
      else
        nxt_ir_cnt = ir_cnt_ff + 8'h01;
    end
    nxt_flags.half_full_flag = nxt_occ > HALF_CNT; // [R17]
    // Compared at full width, so an offset larger than a small DEPTH is never cut short.
    nxt_flags.almost_full_empty_flag = (32'(nxt_occ) <= 32'(offset_ff))
      || (32'(nxt_occ) + 32'(offset_ff) >= 32'(FULL_CNT)); // [R17]
    if (dev_rst) // [R14]
    begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_count = '0;
      nxt_occ = '0;
      nxt_lat = '0;
      nxt_ir_cnt = '0;
      nxt_full_seen = 1'b0;
      nxt_dout = '0;
      nxt_flags = '{input_ready: 1'b0, output_ready: 1'b0, half_full_flag: 1'b0, almost_full_empty_flag: 1'b1};
      if (!aresetn)
      begin
        nxt_cap = '0;
        nxt_offset = DEFAULT_OFFSET;
        nxt_oe = 1'b0;
      end
    end
    else if (rst_rise)
      nxt_offset = pins_s.define_flag_offset_n ? DEFAULT_OFFSET : cap_ff; // [R7] [R8] [R15]
  end

  always_ff @(posedge aclk)
  begin
    wr_ptr_ff <= nxt_wr_ptr;
    rd_ptr_ff <= nxt_rd_ptr;
    count_ff <= nxt_count;
    occ_ff <= nxt_occ;
    cap_ff <= nxt_cap;
    offset_ff <= nxt_offset;
    lat_ff <= nxt_lat;
    ir_cnt_ff <= nxt_ir_cnt;
    full_seen_ff <= nxt_full_seen;
    dout_ff <= nxt_dout;
    oe_ff <= nxt_oe;
    flags_ff <= nxt_flags;
  end

  // Storage has no reset; the pointers decide what is valid.
  always_ff @(posedge aclk)
  begin
    if (push)
      mem[wr_ptr_ff] <= pins_s.data_in; // [R1]
  end

  assign data_out = dout_ff;
  assign data_out_oe = oe_ff;
  assign flags = flags_ff;

  // Sticky events, mask and interrupt.
  logic [EV_W-1:0] status_ff, nxt_status, mask_ff, nxt_mask, events, clr;
  logic irq_ff, nxt_irq;
  logic awready_ff, nxt_awready, bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wr_take, rd_take;

  assign events[EV_FULL] = flags_ff.input_ready && !nxt_flags.input_ready && !dev_rst;
  assign events[EV_EMPTY] = flags_ff.output_ready && !nxt_flags.output_ready && !dev_rst;
  assign events[EV_HALF] = !flags_ff.half_full_flag && nxt_flags.half_full_flag;
  assign events[EV_ALMOST] = !flags_ff.almost_full_empty_flag && nxt_flags.almost_full_empty_flag && !dev_rst;
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
  assign rd_take = s_axi_arvalid && !arready_ff && !rvalid_ff;
  assign clr = (wr_take && s_axi_awaddr == STATUS_ADDR && s_axi_wstrb[0]) ? s_axi_wdata[EV_W-1:0] : '0;

  always_comb
  begin
    // A new event beats a clear in the same cycle.
    nxt_status = (status_ff & ~clr) | events;
    nxt_mask = mask_ff;
    nxt_awready = wr_take;
    nxt_bvalid = bvalid_ff ? !s_axi_bready : awready_ff;
    nxt_bresp = bresp_ff;
    nxt_arready = rd_take;
    nxt_rvalid = rvalid_ff ? !s_axi_rready : arready_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (wr_take)
    begin
      nxt_bresp = RESP_OKAY;
      if (s_axi_awaddr == MASK_ADDR)
      begin
        if (s_axi_wstrb[0])
          nxt_mask = s_axi_wdata[EV_W-1:0];
      end
      else if (s_axi_awaddr != STATUS_ADDR)
        nxt_bresp = RESP_SLVERR;
    end
    if (rd_take)
    begin
      nxt_rresp = RESP_OKAY;
      nxt_rdata = '0;
      unique case (s_axi_araddr)
        STATUS_ADDR: nxt_rdata[EV_W-1:0] = status_ff;
        MASK_ADDR: nxt_rdata[EV_W-1:0] = mask_ff;
        LEVEL_ADDR:
        begin
          nxt_rdata[CNT_W-1:0] = occ_ff;
          nxt_rdata[LEVEL_IR_BIT] = flags_ff.input_ready;
          nxt_rdata[LEVEL_OR_BIT] = flags_ff.output_ready;
          nxt_rdata[LEVEL_HF_BIT] = flags_ff.half_full_flag;
          nxt_rdata[LEVEL_AF_BIT] = flags_ff.almost_full_empty_flag;
        end
        OFFSET_ADDR: nxt_rdata[OFFSET_W-1:0] = offset_ff;
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
    nxt_irq = |(nxt_status & nxt_mask);
    if (!aresetn)
    begin
      nxt_status = STATUS_RESET;
      nxt_mask = MASK_RESET;
      nxt_awready = 1'b0;
      nxt_bvalid = 1'b0;
      nxt_bresp = RESP_OKAY;
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b0;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = '0;
      nxt_irq = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    status_ff <= nxt_status;
    mask_ff <= nxt_mask;
    awready_ff <= nxt_awready;
    bvalid_ff <= nxt_bvalid;
    bresp_ff <= nxt_bresp;
    arready_ff <= nxt_arready;
    rvalid_ff <= nxt_rvalid;
    rresp_ff <= nxt_rresp;
    rdata_ff <= nxt_rdata;
    irq_ff <= nxt_irq;
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = awready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign irq = irq_ff;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_reset_released;
    !pins_s.reset_n ##1 pins_s.reset_n;
  endsequence

  a_write_gate: assert property (count_ff != $past(count_ff) && !$past(pop) && !$past(dev_rst)
    |-> $past(wr_rise && flags_ff.input_ready && pins_s.write_enable_a && pins_s.write_enable_b)) // [R1]
    else $error("Word stored without write qualification.");
  a_ir_sync: assert property ($changed(flags_ff.input_ready) |-> $past(wr_rise) || $past(dev_rst)) // [R2]
    else $error("input_ready moved without a write clock edge.");
  a_offset_capture: assert property (def_fall |=> cap_ff == $past(pins_s.data_in[OFFSET_W-1:0])) // [R5]
    else $error("Offset not captured on the define strobe fall.");
  a_offset_armed: assert property (s_reset_released ##0 !pins_s.define_flag_offset_n |=> offset_ff == $past(cap_ff)) // [R7]
    else $error("Captured offset not armed at reset release.");
  a_offset_default: assert property (s_reset_released ##0 pins_s.define_flag_offset_n |=> offset_ff == DEFAULT_OFFSET) // [R8]
    else $error("Default offset not used at reset release.");
  a_or_latency: assert property ($rose(flags_ff.output_ready) |-> $past(rd_rise && lat_ff == OR_DELAY)) // [R10]
    else $error("output_ready rose before the cascade latency.");
  a_ir_recover: assert property ($rose(flags_ff.input_ready) && $past(full_seen_ff)
    |-> $past(ir_cnt_ff) == IR_DELAY) // [R11]
    else $error("input_ready recovered early after full.");
  a_read_gate: assert property (pop && flags_ff.output_ready |-> pins_s.read_enable_a && pins_s.read_enable_b
    && pins_s.q_drive_enable) // [R12]
    else $error("Read taken without enables.");
  a_reset_state: assert property (dev_rst |=> !flags_ff.input_ready && !flags_ff.output_ready
    && !flags_ff.half_full_flag && flags_ff.almost_full_empty_flag && count_ff == '0) // [R14]
    else $error("Reset state wrong.");
  a_full_ir: assert property (occ_ff == FULL_CNT |-> !flags_ff.input_ready) // [R16]
    else $error("input_ready high while full.");
  a_half_flag: assert property (flags_ff.half_full_flag == (occ_ff > HALF_CNT)) // [R17]
    else $error("half_full_flag disagrees with level.");
  a_irq_level: assert property (irq == |(status_ff & mask_ff))
    else $error("Interrupt level disagrees with status and mask.");

endmodule // fifo_write_flags

// File: fifo_pin_model.sv
// Writer and reader pin model that stands on the far side of the FIFO.
`timescale 1ns/10ps
module fifo_pin_model
  import fifo_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Device pins
  output pin_in_type pins
);
  logic [3:0] wcnt = 4'h0;
  logic [3:0] rcnt = 4'h0;

  initial pins = '{reset_n: 1'b1, define_flag_offset_n: 1'b1, q_drive_enable: 1'b1, default: '0};

  // Both pin clocks run free; each level lasts at least four aclk so the oversampler sees every edge.
  always @(posedge aclk)
  begin
    wcnt <= (wcnt == 4'h7) ? 4'h0 : wcnt + 4'h1;
    rcnt <= (rcnt == 4'h9) ? 4'h0 : rcnt + 4'h1;
    pins.wr_clk <= (wcnt >= 4'h4);
    pins.rd_clk_a <= (rcnt >= 4'h5);
  end

  // Enables and data are held until the synchronised clock edge has surely been taken.
  task automatic write_word(input logic [DATA_W-1:0] d, input logic [1:0] en);
    @(negedge pins.wr_clk);
    pins.data_in <= d;
    {pins.write_enable_a, pins.write_enable_b} <= en;
    @(posedge pins.wr_clk);
    repeat (4) @(posedge aclk);
    pins.data_in <= ~d;
    {pins.write_enable_a, pins.write_enable_b} <= 2'h0;
  endtask

  task automatic read_word(input logic [2:0] en);
    @(negedge pins.rd_clk_a);
    {pins.q_drive_enable, pins.read_enable_a, pins.read_enable_b} <= en;
    @(posedge pins.rd_clk_a);
    repeat (4) @(posedge aclk);
    {pins.q_drive_enable, pins.read_enable_a, pins.read_enable_b} <= 3'h4;
  endtask

  // Enables are raised only inside reset, where no word can be stored.
  task automatic reset_pin(input logic use_off, input logic [DATA_W-1:0] d);
    pins.reset_n <= 1'b0;
    repeat (2) @(posedge pins.rd_clk_a);
    pins.data_in <= d;
    {pins.write_enable_a, pins.write_enable_b} <= 2'h3;
    repeat (3) @(posedge aclk);
    pins.define_flag_offset_n <= !use_off;
    repeat (3) @(posedge pins.rd_clk_a);
    repeat (2) @(posedge aclk);
    pins.reset_n <= 1'b1;
    {pins.write_enable_a, pins.write_enable_b} <= 2'h0;
    repeat (6) @(posedge aclk);
    pins.define_flag_offset_n <= 1'b1;
    pins.data_in <= ~d;
  endtask
endmodule // fifo_pin_model

// File: dual_clock_fifo_write_and_flags_test.sv
// Self-checking testbench of the FIFO write block and its register port.
`timescale 1ns/10ps
module dual_clock_fifo_write_and_flags_test
  import fifo_pkg::*;
();
  localparam int DEP = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  pin_in_type pins;
  logic [DATA_W-1:0] data_out;
  logic oe;
  flags_type flags;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic irq;
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  int n;
  logic [2:0] blk [3] = '{3'h3, 3'h5, 3'h6};

  fifo_write_flags #(.DEPTH(DEP), .CASCADE_N(1)) dut_u (.aclk, .aresetn, .pins, .data_out, .data_out_oe(oe),
    .flags, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  fifo_pin_model model_u (.aclk(aclk), .pins(pins));

  initial forever #2.5 aclk = ~aclk;

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      aw = aw | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a, rd, rs);
    check(rd & m, e);
  endtask

  task automatic wait_flag(input int idx, input logic v);
    int k = 0;
    while (flags[idx] !== v && k < 400)
    begin
      @(posedge aclk);
      k++;
    end
    check({31'h0, flags[idx]}, {31'h0, v});
  endtask

  // The longest path needs under two thousand cycles, so this limit only ends a real hang.
  initial
  begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({28'h0, flags}, 32'h1);
    chk_reg(OFFSET_ADDR, 32'h1ff, 32'h100);
    model_u.reset_pin(1'b0, 18'h3ff07);
    chk_reg(OFFSET_ADDR, 32'h1ff, 32'h100);
    wait_flag(3, 1'b1);
    model_u.reset_pin(1'b1, 18'h3fe05);
    chk_reg(OFFSET_ADDR, 32'h1ff, 32'h005);
    wait_flag(3, 1'b1);
    for (int i = 1; i < 3; i++)
    begin
      model_u.write_word(18'h0abcd, 2'(i));
      repeat (8) @(posedge aclk);
      chk_reg(LEVEL_ADDR, 32'h7ff, 32'h0);
    end
    model_u.write_word(18'h2aaaa, 2'h3);
    wait_flag(2, 1'b1);
    check({14'h0, data_out}, 32'h2aaaa);
    model_u.write_word(18'h15555, 2'h3);
    for (int i = 0; i < 3; i++)
    begin
      model_u.read_word(blk[i]);
      check({14'h0, data_out}, 32'h2aaaa);
      check({31'h0, oe}, {31'h0, blk[i][2]});
    end
    model_u.read_word(3'h7);
    repeat (2) @(posedge aclk);
    check({14'h0, data_out}, 32'h15555);
    axi_wr(STATUS_ADDR, 32'hf, rs);
    for (int i = 0; i < DEP + 1; i++) model_u.write_word(DATA_W'(i + 256), 2'h3);
    repeat (8) @(posedge aclk);
    check({28'h0, flags}, 32'h7);
    chk_reg(LEVEL_ADDR, 32'h7ff, DEP);
    chk_reg(STATUS_ADDR, 32'hf, 32'hd);
    axi_wr(MASK_ADDR, 32'h1, rs);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    axi_wr(STATUS_ADDR, 32'hd, rs);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    model_u.read_word(3'h7);
    wait_flag(3, 1'b1);
    check({14'h0, data_out}, 32'h100);
    axi_rd(8'h10, rd, rs);
    check(rd, 32'h0);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_wr(LEVEL_ADDR, 32'h0, rs);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_wr(MASK_ADDR, 32'h5, rs);
    chk_reg(MASK_ADDR, 32'hf, 32'h5);
    n = 0;
    while (flags.output_ready === 1'b1 && n < 40)
    begin
      model_u.read_word(3'h7);
      repeat (2) @(posedge aclk);
      n++;
    end
    check(32'(n), 32'd15);
    check({28'h0, flags}, 32'h9);
    chk_reg(STATUS_ADDR, 32'hf, 32'ha);
    check({31'h0, irq}, 32'h0);
    axi_wr(MASK_ADDR, 32'ha, rs);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    wrap_up();
  end
endmodule // dual_clock_fifo_write_and_flags_test
